// ---- logic/fbrr_top.sv ----
// Burst-read sequencer and hard-reset handling of a dual-bank parallel flash
`timescale 1ns/1ns

module fbrr_top (
  // System clock and reset
  input  wire logic                          clk,
  input  wire logic                          rstn,
  // Hard reset pin, asynchronous to both clocks
  input  wire logic                          hardResetN,
  // Program and erase engine
  input  wire logic                          progEraseBusy,
  output logic                               opAbort,
  output logic                               readyBusyOut,
  // Configuration register access
  input  wire logic                          cfgWrite,
  input  wire logic [fbrr_pkg::CFG_W-1:0]    cfgWrData,
  output logic      [fbrr_pkg::CFG_W-1:0]    cfgRdData,
  // Burst link, on the host's clock
  input  wire logic                          burstClk,
  input  wire logic                          chipSelN,
  input  wire logic                          outGateN,
  input  wire logic                          addressValidStrobeN,
  input  wire logic [fbrr_pkg::ADDR_W-1:0]   addrIn,
  input  wire logic                          regSpaceSel,
  input  wire logic                          securedSel,
  // Array read port, on the link clock
  output logic      [fbrr_pkg::ADDR_W-1:0]   arrayAddr,
  input  wire logic [fbrr_pkg::DATA_W-1:0]   arrayData,
  // Data bus and end-of-burst flag pins
  output logic      [fbrr_pkg::DATA_W-1:0]   dataOut,
  output logic                               dataOe,
  output logic                               dataInvalid,
  output logic                               endOfBurstFlagOut,
  output logic                               endOfBurstFlagOe
);

  // ----------------------------------------------------------------
  // System clock domain
  // ----------------------------------------------------------------
  logic                         hrC1_q, hrC2_q;   // Hard reset pin synchroniser
  logic                         hardRst;          // Hard reset held, synchronised
  logic [fbrr_pkg::CFG_W-1:0]   cfg_q, cfg_d;     // Configuration register
  logic                         cfgTgl_q;         // Flips on every configuration change
  logic [fbrr_pkg::PROC_CNT_W-1:0] procCnt_q;     // Reset processing countdown
  logic                         readyBusy_q;      // Ready/busy pin value
  logic                         opAbort_q;        // Abort request to the engine

  assign hardRst = !hrC2_q;

  // Two flops before the pin is used
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hrC1_q <= 1'b1;
      hrC2_q <= 1'b1;
    end else begin
      hrC1_q <= hardResetN;
      hrC2_q <= hrC1_q;
    end
  end

  // Next configuration: reset wins, writes ignored while the engine runs
  always_comb begin
    cfg_d = cfg_q;
    if (hardRst) begin
      cfg_d = fbrr_pkg::CFG_RESET;
    end else if (cfgWrite && !progEraseBusy) begin
      cfg_d = cfgWrData;
    end
  end

  // Configuration register with change toggle for the link side
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_q    <= fbrr_pkg::CFG_RESET;
      cfgTgl_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      if (cfg_d != cfg_q) begin
        cfgTgl_q <= !cfgTgl_q;
      end
    end
  end

  // Abort and reset processing; busy held while the aborted job recovers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      procCnt_q   <= '0;
      readyBusy_q <= 1'b1;
      opAbort_q   <= 1'b0;
    end else begin
      opAbort_q <= hardRst;
      if (hardRst && (progEraseBusy || procCnt_q != '0)) begin
        procCnt_q <= fbrr_pkg::PROC_CNT_W'(fbrr_pkg::RESET_PROC_CYC);
      end else if (procCnt_q != '0) begin
        procCnt_q <= procCnt_q - 1'b1;
      end
      readyBusy_q <= !progEraseBusy && (procCnt_q == '0);
    end
  end

  assign opAbort      = opAbort_q;
  assign readyBusyOut = readyBusy_q;
  assign cfgRdData    = cfg_q;

  // ----------------------------------------------------------------
  // Link clock domain: reset and configuration crossing
  // ----------------------------------------------------------------
  logic                         hrL1_q, hrL2_q;   // Hard reset pin synchroniser
  logic                         rsL1_q, rsL2_q;   // System reset synchroniser
  logic                         linkRstN;         // Link logic reset, active low
  logic                         tgS1_q, tgS2_q, tgS3_q; // Toggle synchroniser and edge
  logic [fbrr_pkg::CFG_W-1:0]   lcfg_q;           // Link copy of configuration

  assign linkRstN = hrL2_q && rsL2_q;

  // Resets enter the link domain through two flops each
  always_ff @(posedge burstClk) begin
    hrL1_q <= hardResetN;
    hrL2_q <= hrL1_q;
    rsL1_q <= rstn;
    rsL2_q <= rsL1_q;
  end

  // Word crossing by toggle: the source word is stable long before the toggle lands
  always_ff @(posedge burstClk) begin
    if (!linkRstN) begin
      tgS1_q <= 1'b0;
      tgS2_q <= 1'b0;
      tgS3_q <= 1'b0;
      lcfg_q <= fbrr_pkg::CFG_RESET;
    end else begin
      tgS1_q <= cfgTgl_q;
      tgS2_q <= tgS1_q;
      tgS3_q <= tgS2_q;
      if (tgS2_q != tgS3_q) begin
        lcfg_q <= cfg_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link clock domain: decode of the configuration
  // ----------------------------------------------------------------
  logic [2:0]                   blCode;           // Burst-length field
  logic [2:0]                   lenMask;          // Burst length minus one
  logic                         burstOn;          // Burst protocol active
  logic [4:0]                   waitCycles;       // Initial wait in clocks
  logic [2:0]                   eobIdx;           // Word index that drops the flag

  assign blCode     = lcfg_q[fbrr_pkg::BL_LSB +: fbrr_pkg::BL_W];
  assign waitCycles = 5'(lcfg_q[fbrr_pkg::IAD_LSB +: fbrr_pkg::IAD_W]) + fbrr_pkg::WAIT_BASE;
  assign eobIdx     = lenMask - 3'(lcfg_q[fbrr_pkg::WC_BIT]);

  // Length field picks the wrap group; unknown codes disable bursts
  always_comb begin
    lenMask = 3'h0;
    unique case (blCode)
      fbrr_pkg::BL_2: lenMask = 3'h1;
      fbrr_pkg::BL_4: lenMask = 3'h3;
      fbrr_pkg::BL_8: lenMask = 3'h7;
      default:        lenMask = 3'h0;
    endcase
  end

  // Only the one valid mode/edge/output combination supports bursts
  assign burstOn = !lcfg_q[fbrr_pkg::RM_BIT] && lcfg_q[fbrr_pkg::CC_BIT]
                   && !lcfg_q[fbrr_pkg::DOC_BIT] && (blCode != fbrr_pkg::BL_OFF)
                   && (lenMask != 3'h0);

  // ----------------------------------------------------------------
  // Link clock domain: burst sequencer
  // ----------------------------------------------------------------
  fbrr_pkg::fbrr_lstate_t       state_q;          // Sequencer state
  logic [4:0]                   waitCnt_q;        // Wait states left
  logic [2:0]                   xferIdx_q;        // Index of word on the bus
  logic [2:0]                   loadIdx;          // Index of word being loaded
  logic [fbrr_pkg::ADDR_W-1:0]  arrayAddr_q;      // Word fetched next
  logic [fbrr_pkg::ADDR_W-1:0]  nextAddr;         // Wrapped successor address
  logic                         secSel_q;         // Burst targets secured sector
  logic                         start;            // Address latched this edge
  logic                         loading;          // A word goes out this edge
  logic [fbrr_pkg::DATA_W-1:0]  dataOut_q;        // Data pin value
  logic                         dataOe_q;         // Data pin enable
  logic                         dataInvalid_q;    // Word beyond secured boundary
  logic                         eobVal_q;         // Flag pin value
  logic                         eobOe_q;          // Flag pin enable

  assign start   = !chipSelN && !addressValidStrobeN;
  assign loading = !chipSelN && !start &&
                   (((state_q == fbrr_pkg::LS_WAIT) && (waitCnt_q == 5'h01)) ||
                    (state_q == fbrr_pkg::LS_XFER));
  assign loadIdx = (state_q == fbrr_pkg::LS_WAIT) ? 3'h0 : ((xferIdx_q + 3'h1) & lenMask);
  // Increment inside the aligned group only
  assign nextAddr = {arrayAddr_q[fbrr_pkg::ADDR_W-1:3],
                     (arrayAddr_q[2:0] & ~lenMask) | ((arrayAddr_q[2:0] + 3'h1) & lenMask)};

  // State: select loss and strobe override everything but reset
  always_ff @(posedge burstClk) begin
    if (!linkRstN) begin
      state_q <= fbrr_pkg::LS_IDLE;
    end else if (chipSelN) begin
      state_q <= fbrr_pkg::LS_IDLE;
    end else if (start) begin
      state_q <= (burstOn && !regSpaceSel) ? fbrr_pkg::LS_WAIT
                                           : fbrr_pkg::LS_SINGLE;
    end else begin
      unique case (state_q)
        fbrr_pkg::LS_WAIT: begin
          if (waitCnt_q == 5'h01) begin
            state_q <= fbrr_pkg::LS_XFER;
          end
        end
        fbrr_pkg::LS_IDLE,
        fbrr_pkg::LS_XFER,
        fbrr_pkg::LS_SINGLE: state_q <= state_q;
        default: state_q <= fbrr_pkg::LS_IDLE;
      endcase
    end
  end

  // Wait counter loaded at the address latch
  always_ff @(posedge burstClk) begin
    if (!linkRstN) begin
      waitCnt_q <= 5'h00;
    end else if (start) begin
      waitCnt_q <= waitCycles;
    end else if ((state_q == fbrr_pkg::LS_WAIT) && (waitCnt_q > 5'h01)) begin
      waitCnt_q <= waitCnt_q - 5'h01;
    end
  end

  // Address latch and wrapping advance
  always_ff @(posedge burstClk) begin
    if (!linkRstN) begin
      arrayAddr_q <= '0;
      secSel_q    <= 1'b0;
      xferIdx_q   <= 3'h0;
    end else if (start) begin
      arrayAddr_q <= addrIn;
      secSel_q    <= securedSel;
      xferIdx_q   <= 3'h0;
    end else if (loading) begin
      arrayAddr_q <= nextAddr;
      xferIdx_q   <= loadIdx;
    end
  end

  // Data word and secured-sector marking; single reads keep re-sampling one address
  always_ff @(posedge burstClk) begin
    if (!linkRstN) begin
      dataOut_q     <= '0;
      dataInvalid_q <= 1'b0;
    end else if (loading || (state_q == fbrr_pkg::LS_SINGLE)) begin
      dataOut_q     <= arrayData;
      dataInvalid_q <= secSel_q &&
                       (arrayAddr_q[fbrr_pkg::ADDR_W-1:fbrr_pkg::SEC_WORD_LSB] != '0);
    end
  end

  // Pin enables: gate only floats, the sequence keeps running
  always_ff @(posedge burstClk) begin
    if (!linkRstN) begin
      dataOe_q <= 1'b0;
      eobOe_q  <= 1'b0;
    end else begin
      dataOe_q <= !outGateN && (loading ||
                  (!chipSelN && !start && (state_q == fbrr_pkg::LS_SINGLE)));
      eobOe_q  <= !outGateN && !chipSelN;
    end
  end

  // End-of-burst flag: low for one clock on the chosen transfer of each lap
  always_ff @(posedge burstClk) begin
    if (!linkRstN) begin
      eobVal_q <= 1'b1;
    end else begin
      eobVal_q <= !(loading && (loadIdx == eobIdx));
    end
  end

  assign arrayAddr         = arrayAddr_q;
  assign dataOut           = dataOut_q;
  assign dataOe            = dataOe_q;
  assign dataInvalid       = dataInvalid_q;
  assign endOfBurstFlagOut = eobVal_q;
  assign endOfBurstFlagOe  = eobOe_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [4:0] waitSeen_q;                         // Clocks spent in wait
  // Counts wait clocks since the last latch
  always_ff @(posedge burstClk) begin
    if (!linkRstN || start) begin
      waitSeen_q <= 5'h00;
    end else if (state_q == fbrr_pkg::LS_WAIT) begin
      waitSeen_q <= waitSeen_q + 5'h01;
    end else begin
      waitSeen_q <= 5'h00;
    end
  end
  AST_RESET_FLOAT: assert property (@(posedge burstClk) disable iff (!rsL2_q)
    !hrL2_q |=> !dataOe_q && !eobOe_q && (state_q == fbrr_pkg::LS_IDLE))
    else $error("bus driven during hard reset");
  AST_RESET_CFG: assert property (@(posedge clk) disable iff (!rstn)
    hardRst |=> (cfg_q == fbrr_pkg::CFG_RESET) && opAbort_q)
    else $error("configuration not restored by hard reset");
  AST_BUSY_ABORT: assert property (@(posedge clk) disable iff (!rstn)
    hardRst && progEraseBusy |=> !readyBusy_q ##1 !readyBusy_q)
    else $error("ready asserted during abort processing");
  AST_CS_EXIT: assert property (@(posedge burstClk) disable iff (!linkRstN)
    chipSelN |=> !dataOe_q && (state_q == fbrr_pkg::LS_IDLE))
    else $error("burst not left on chip select high");
  AST_WAIT_LEN: assert property (@(posedge burstClk) disable iff (!linkRstN)
    (state_q == fbrr_pkg::LS_XFER) && $past(state_q == fbrr_pkg::LS_WAIT)
      |-> waitSeen_q == $past(waitCycles))
    else $error("wrong number of wait states");
  AST_WRAP_ORDER: assert property (@(posedge burstClk) disable iff (!linkRstN)
    (state_q == fbrr_pkg::LS_XFER) && $past(state_q == fbrr_pkg::LS_XFER) && $stable(lenMask)
      |-> xferIdx_q == (($past(xferIdx_q) + 3'h1) & lenMask))
    else $error("burst order broken");
  AST_EOB_ONE: assert property (@(posedge burstClk) disable iff (!linkRstN)
    !eobVal_q |=> eobVal_q)
    else $error("end flag low longer than one clock");
  AST_EOB_POS: assert property (@(posedge burstClk) disable iff (!linkRstN)
    $fell(eobVal_q) |-> (xferIdx_q == $past(eobIdx)) && (state_q == fbrr_pkg::LS_XFER))
    else $error("end flag on wrong transfer");
  AST_GATE_FLOAT: assert property (@(posedge burstClk) disable iff (!linkRstN)
    outGateN && !chipSelN && addressValidStrobeN && (state_q == fbrr_pkg::LS_XFER)
      |=> !dataOe_q && !eobOe_q && (state_q == fbrr_pkg::LS_XFER))
    else $error("gate high did not just float the bus");
  AST_ASYNC_DEFAULT: assert property (@(posedge burstClk) disable iff (!linkRstN)
    start && lcfg_q[fbrr_pkg::RM_BIT] |=> state_q == fbrr_pkg::LS_SINGLE)
    else $error("burst started in asynchronous mode");
  COV_FULL_LAP: cover property (@(posedge burstClk) disable iff (!linkRstN)
    (state_q == fbrr_pkg::LS_XFER) && $fell(eobVal_q) && (lenMask == 3'h7));
  COV_RESTART: cover property (@(posedge burstClk) disable iff (!linkRstN)
    (state_q == fbrr_pkg::LS_XFER) && start);
  COV_GATE_MID: cover property (@(posedge burstClk) disable iff (!linkRstN)
    (state_q == fbrr_pkg::LS_XFER) && outGateN ##1 !outGateN);
endmodule : fbrr_top

// ---- logic/fbrr_pkg.sv ----
// Constants and types shared by the flash burst-read and hard-reset block
package fbrr_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CFG_W  = 16;            // Configuration register width
  localparam int DATA_W = 32;            // One double word
  localparam int ADDR_W = 19;            // Double-word address width

  // ----------------------------------------------------------------
  // Configuration register layout and value after reset
  // ----------------------------------------------------------------
  localparam logic [15:0] CFG_RESET = 16'h9CC0; // Async mode, 9-cycle wait, bursts off, rising edge
  localparam int RM_BIT  = 15;           // Read-mode bit, 1 = asynchronous
  localparam int IAD_LSB = 10;           // Initial wait field, low bit
  localparam int IAD_W   = 4;            // Initial wait field width
  localparam int DOC_BIT = 9;            // Data-hold bit
  localparam int WC_BIT  = 8;            // Flag-timing bit
  localparam int CC_BIT  = 6;            // Edge-select bit
  localparam int BL_LSB  = 0;            // Burst-length field, low bit
  localparam int BL_W    = 3;            // Burst-length field width

  // ----------------------------------------------------------------
  // Burst-length codes and wait encoding
  // ----------------------------------------------------------------
  localparam logic [2:0] BL_OFF = 3'h0;  // Bursts disabled
  localparam logic [2:0] BL_2   = 3'h1;  // Two double words
  localparam logic [2:0] BL_4   = 3'h2;  // Four double words
  localparam logic [2:0] BL_8   = 3'h3;  // Eight double words
  localparam logic [4:0] WAIT_BASE = 5'h02; // Wait cycles for field code 0

  // ----------------------------------------------------------------
  // Secured sector boundary
  // ----------------------------------------------------------------
  localparam int SEC_BYTES    = 256;     // Secured sector size in bytes
  localparam int SEC_WORD_LSB = 6;       // log2(SEC_BYTES / 4)

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 20;    // System clock period
  localparam int RESET_PROC_NS  = 20000; // Internal reset processing after an abort
  localparam int RESET_PROC_CYC = (RESET_PROC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROC_CNT_W     = 11;    // Holds RESET_PROC_CYC

  // ----------------------------------------------------------------
  // Link-side sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    LS_IDLE   = 4'b0001,                 // Nothing selected
    LS_WAIT   = 4'b0010,                 // Initial wait states
    LS_XFER   = 4'b0100,                 // Burst words on the bus
    LS_SINGLE = 4'b1000                  // Single-cycle read
  } fbrr_lstate_t;

endpackage : fbrr_pkg

// ---- dv/fbrr_host_model.sv ----
// Host memory controller model driving the burst link pins
`timescale 1ns/1ns

module fbrr_host_model (
  // Link clock and controls
  output logic                        burstClk,
  output logic                        chipSelN,
  output logic                        outGateN,
  output logic                        addressValidStrobeN,
  // Address and space selects
  output logic [fbrr_pkg::ADDR_W-1:0] addrIn,
  output logic                        regSpaceSel,
  output logic                        securedSel
);
  // ----------------------------------------------------------------
  // Link clock, free running so a hard reset still reaches the link
  // ----------------------------------------------------------------
  initial begin
    burstClk = 1'b0;
    forever begin
      #7 burstClk = 1'b1;
      #8 burstClk = 1'b0;
    end
  end

  // Idle bus at time zero
  initial begin
    chipSelN            = 1'b1;
    outGateN            = 1'b1;
    addressValidStrobeN = 1'b1;
    addrIn              = '0;
    regSpaceSel         = 1'b0;
    securedSel          = 1'b0;
  end

  // Strobe a start address; returns at the latch edge
  task automatic start(input logic [fbrr_pkg::ADDR_W-1:0] a, input logic r, input logic s);
    @(posedge burstClk);
    chipSelN            <= 1'b0;
    addressValidStrobeN <= 1'b0;
    outGateN            <= 1'b0;
    addrIn              <= a;
    regSpaceSel         <= r;
    securedSel          <= s;
    @(posedge burstClk);
    addressValidStrobeN <= 1'b1;
    addrIn              <= ~a; // Released lines must not keep the old address
  endtask : start

  // Output gate level, called just after a rising edge
  task automatic gate(input logic v);
    outGateN <= v;
  endtask : gate

  // Deselect ends the burst
  task automatic release_bus();
    chipSelN <= 1'b1;
    outGateN <= 1'b1;
  endtask : release_bus
endmodule : fbrr_host_model

// ---- dv/test_fbrr_top.sv ----
// Self-checking bench for the flash burst-read and hard-reset block
`timescale 1ns/1ns

module test_fbrr_top;
  logic        clk, rstn, hardResetN, progEraseBusy, cfgWrite;
  logic [15:0] cfgWrData, cfgRdData;
  logic        burstClk, chipSelN, outGateN, addressValidStrobeN, regSpaceSel, securedSel;
  logic [18:0] addrIn, arrayAddr;
  logic [31:0] arrayData, dataOut;
  logic        opAbort, readyBusyOut, dataOe, dataInvalid, endOfBurstFlagOut, endOfBurstFlagOe;
  int          failCount;  // Mismatches seen
  int          numChecks;  // Comparisons made

  // Array content: each word carries its own address
  function automatic logic [31:0] word(input logic [18:0] a);
    return {~a[12:0], a};
  endfunction : word
  assign arrayData = word(arrayAddr);

  fbrr_host_model host_u (.burstClk(burstClk), .chipSelN(chipSelN), .outGateN(outGateN),
    .addressValidStrobeN(addressValidStrobeN), .addrIn(addrIn), .regSpaceSel(regSpaceSel),
    .securedSel(securedSel));

  fbrr_top dut_u (.clk(clk), .rstn(rstn), .hardResetN(hardResetN), .progEraseBusy(progEraseBusy),
    .opAbort(opAbort), .readyBusyOut(readyBusyOut), .cfgWrite(cfgWrite), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .burstClk(burstClk), .chipSelN(chipSelN), .outGateN(outGateN),
    .addressValidStrobeN(addressValidStrobeN), .addrIn(addrIn), .regSpaceSel(regSpaceSel),
    .securedSel(securedSel), .arrayAddr(arrayAddr), .arrayData(arrayData), .dataOut(dataOut),
    .dataOe(dataOe), .dataInvalid(dataInvalid), .endOfBurstFlagOut(endOfBurstFlagOut),
    .endOfBurstFlagOe(endOfBurstFlagOe));

  // System clock, 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // Write the configuration, then leave time for the crossing
  task automatic wr_cfg(input logic [15:0] v);
    @(posedge clk);
    cfgWrite  <= 1'b1;
    cfgWrData <= v;
    @(posedge clk);
    cfgWrite <= 1'b0;
    @(negedge clk);
    chk("cfg", v, cfgRdData);
    repeat (12) @(posedge burstClk);
  endtask : wr_cfg

  // Burst with wrap; one word gated off at index gOff
  task automatic burst(input logic [2:0] bl, input logic [3:0] wt, input logic wc,
                       input logic [18:0] a, input logic sec, input int gOff);
    int          len;
    logic [18:0] ea;
    logic [15:0] cfg;
    len = 1 << bl;
    cfg = {2'b00, wt, 1'b0, wc, 2'b11, 3'h0, bl};
    // Deselect before a new setting, so a running lap never sees its length change
    @(posedge burstClk);
    if (cfgRdData !== cfg) begin
      host_u.release_bus();
    end
    wr_cfg(cfg);
    host_u.start(a, 1'b0, sec);
    repeat (wt + 2) @(posedge burstClk);
    for (int i = 0; i < 2 * len; i++) begin
      ea = (a & ~19'(len - 1)) | ((a + 19'(i)) & 19'(len - 1));
      @(negedge burstClk);
      chk("oe", i != gOff, dataOe);
      chk("flagOe", i != gOff, endOfBurstFlagOe);
      if (i != gOff) begin
        chk("data", word(ea), dataOut);
        chk("flag", (i % len) != len - 1 - wc, endOfBurstFlagOut);
        chk("invalid", sec && a[18:6] != 0, dataInvalid);
      end
      @(posedge burstClk);
      host_u.gate(i + 2 == gOff);
    end
    $display("burst of %0d done", len);
  endtask : burst

  // Single read: data stays put over the 12 clocks checked
  task automatic single(input logic [18:0] a, input logic r);
    host_u.start(a, r, 1'b0);
    repeat (2) @(posedge burstClk);
    for (int i = 0; i < 12; i++) begin
      @(negedge burstClk);
      chk("single", word(a), dataOut);
      chk("singleOe", 1'b1, dataOe);
    end
    $display("single read done");
  endtask : single

  // Hard reset during a burst with the engine busy
  task automatic hard_reset_test();
    int k;
    host_u.start(19'h00010, 1'b0, 1'b0);
    repeat (12) @(posedge burstClk);
    @(posedge clk);
    progEraseBusy <= 1'b1;
    hardResetN    <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("abort", 1'b1, opAbort);
    chk("floatRst", 1'b0, dataOe);
    chk("busy", 1'b0, readyBusyOut);
    chk("cfgDefault", 16'h9CC0, cfgRdData);
    @(posedge clk);
    hardResetN    <= 1'b1;
    progEraseBusy <= 1'b0;
    k = 0;
    // Ready is looked at on the falling edge, clear of its launch edge
    while (readyBusyOut !== 1'b1 && k < 1200) begin
      @(negedge clk);
      k++;
    end
    if (k == 1200) begin
      failCount++;
      end_sim();
    end
    chk("recovery", 1'b1, k >= fbrr_pkg::RESET_PROC_CYC);
    // Engine rewrites the damaged words; a setting written meanwhile is dropped
    @(posedge clk);
    progEraseBusy <= 1'b1;
    cfgWrite      <= 1'b1;
    cfgWrData     <= 16'h1CC3;
    @(posedge clk);
    cfgWrite <= 1'b0;
    @(negedge clk);
    chk("cfgBusy", fbrr_pkg::CFG_RESET, cfgRdData);
    chk("busyRun", 1'b0, readyBusyOut);
    @(posedge clk);
    progEraseBusy <= 1'b0;
    $display("hard reset done");
  endtask : hard_reset_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn          = 1'b0;
    hardResetN    = 1'b1;
    progEraseBusy = 1'b0;
    cfgWrite      = 1'b0;
    cfgWrData     = '0;
    failCount     = 0;
    numChecks     = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("cfgReset", 16'h9CC0, cfgRdData);
    chk("ready", 1'b1, readyBusyOut);
    repeat (4) @(posedge burstClk);
    burst(fbrr_pkg::BL_2, 4'h0, 1'b0, 19'h00001, 1'b1, 99);
    burst(fbrr_pkg::BL_4, 4'h1, 1'b1, 19'h00045, 1'b0, 3);
    burst(fbrr_pkg::BL_8, 4'h7, 1'b0, 19'h00043, 1'b1, 5);
    burst(fbrr_pkg::BL_8, 4'h7, 1'b0, 19'h00016, 1'b0, 99);
    @(posedge burstClk);
    host_u.release_bus();
    repeat (2) @(posedge burstClk);
    @(negedge burstClk);
    chk("csFloat", 1'b0, dataOe);
    chk("csFlag", 1'b0, endOfBurstFlagOe);
    hard_reset_test();
    single(19'h00123, 1'b0);
    wr_cfg(16'h1CC0);
    single(19'h00124, 1'b0);
    wr_cfg(16'h1CC3);
    single(19'h00077, 1'b1);
    end_sim();
  end
endmodule : test_fbrr_top
